// ===== ledmg_pkg.sv
package ledmg_pkg;
	// Register offsets
	localparam logic [6:0] OFF_MODE_CFG = 7'h00;
	localparam logic [6:0] OFF_MODE_STAT = 7'h01;
	localparam logic [6:0] OFF_STATE_SEL0 = 7'h02;
	localparam logic [6:0] OFF_STATE_SEL3 = 7'h05;
	localparam logic [6:0] OFF_GRP_DUTY = 7'h06;
	localparam logic [6:0] OFF_GRP_PERIOD = 7'h07;
	localparam logic [6:0] OFF_CHAN_DUTY0 = 7'h08;
	localparam logic [6:0] OFF_CHAN_DUTY15 = 7'h17;
	localparam logic [6:0] OFF_BCAST_DUTY = 7'h44;
	localparam logic [6:0] OFF_FAULT0 = 7'h46;
	localparam logic [6:0] OFF_FAULT3 = 7'h49;
	// Field positions, first mode register
	localparam int B_AUTOINC_FLAG = 7;
	localparam int B_AUTOINC_HI = 6;
	localparam int B_AUTOINC_LO = 5;
	localparam int B_SLEEP = 4;
	localparam int B_SUBADDR1_RESPOND = 3;
	localparam int B_SUBADDR2_RESPOND = 2;
	localparam int B_SUBADDR3_RESPOND = 1;
	localparam int B_BCAST = 0;
	// Field positions, second mode register
	localparam int B_THERMAL = 7;
	localparam int B_ERROR = 6;
	localparam int B_BLINK_SEL = 5;
	localparam int B_FAULT_CLR = 4;
	localparam int B_UPD_ACK = 3;
	localparam int B_EXP_CURVE = 2;
	localparam int B_RSVD1 = 0;
	// Values after reset, and the full-duty code
	localparam logic [2:0] RST_SUB = 3'h4;
	localparam logic RST_BCAST = 1'b1;
	localparam logic [1:0] RST_STATE = 2'h2;
	localparam logic [7:0] RST_GRP_DUTY = 8'hFF;
	localparam logic [7:0] RST_GRP_PERIOD = 8'h00;
	localparam logic [7:0] RST_CHAN_DUTY = 8'h00;
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	// Output-state codes
	localparam logic [1:0] ST_OFF = 2'h0;
	localparam logic [1:0] ST_ON = 2'h1;
	localparam logic [1:0] ST_PWM = 2'h2;
	localparam logic [1:0] ST_GRP = 2'h3;
	// Timing
	localparam longint CLK_HZ = 64'd25000000;
	localparam longint WAKE_US = 64'd500;
	localparam int WAKE_CYC = int'(WAKE_US * CLK_HZ / 64'd1000000);
	localparam longint CHAN_HZ = 64'd31250;
	localparam int CHAN_CYC = int'(CLK_HZ / CHAN_HZ);
	localparam int DUTY_STEPS = 256;
	localparam longint BLINK_DIV_X100 = 64'd1526;
	localparam int BLINK_STEP_CYC =
		int'(CLK_HZ * 64'd100 / (BLINK_DIV_X100 * 64'd256));

	typedef enum logic [1:0] {OSC_RUN, OSC_OFF, OSC_WAKE} ledmg_osc_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [6:0] addr;
		logic [7:0] wdata;
	} ledmg_bus_t;
endpackage : ledmg_pkg

// ===== ledmg_top.sv
`timescale 1ns/1ps
module ledmg_top #(
	parameter int CHANNELS = 16,
	parameter int WAKE_CYC = ledmg_pkg::WAKE_CYC,
	parameter int BLINK_STEP_CYC = ledmg_pkg::BLINK_STEP_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Register access from the serial bus engine
	input wire ledmg_pkg::ledmg_bus_t BUS_REQ,
	input wire logic BUS_ACK,
	input wire logic BUS_STOP,
	output logic [7:0] BUS_RDATA,
	// Address response enables and auto-increment range
	output logic [2:0] SUBADDR_EN,
	output logic BCAST_EN,
	output logic [1:0] AUTOINC_RANGE,
	// Oscillator and gradation control
	output logic OSC_RUN,
	output logic EXP_CURVE,
	// Fault detection
	input wire logic [15:0] FAULT_OPEN,
	input wire logic [15:0] FAULT_SHORT,
	input wire logic THERMAL,
	// LED pins
	input wire logic OE_N,
	output logic [15:0] LED
);
	localparam int CW = $clog2(ledmg_pkg::CHAN_CYC);
	localparam int PW = $clog2(BLINK_STEP_CYC + 1);
	localparam int WW = $clog2(WAKE_CYC + 1);

	logic [1:0] autoinc_range_r;
	logic sleep_r;
	logic [2:0] subaddr_respond_r;
	logic broadcast_respond_r;
	logic group_blink_select_r;
	logic update_on_ack_r;
	logic exp_curve_select_r;
	logic thermal_flag_r;
	logic [2*CHANNELS-1:0] fault_flags_r;
	logic [2*CHANNELS-1:0] sel_sh_r;
	logic [2*CHANNELS-1:0] sel_r;
	logic [7:0] gduty_sh_r;
	logic [7:0] gduty_r;
	logic [7:0] gperiod_sh_r;
	logic [7:0] gperiod_r;
	logic [7:0] duty_sh_r [CHANNELS];
	logic [7:0] duty_r [CHANNELS];
	logic [7:0] rdata_r;
	ledmg_pkg::ledmg_osc_t osc_r;
	logic [WW-1:0] wake_cnt_r;
	logic [CW-1:0] chan_cnt_r;
	logic [7:0] gphase_r;
	logic [PW-1:0] pre_r;
	logic [7:0] bsub_r;
	logic [CHANNELS-1:0] led_r;
	logic osc_run_r;
	logic osc_run;
	logic upd;
	logic wr;
	logic clr;
	logic chan_wrap;
	logic gstep;
	logic grp_on;
	logic [6:0] a;
	logic [7:0] d;

	assign a = BUS_REQ.addr;
	assign d = BUS_REQ.wdata;
	assign wr = BUS_REQ.we;
	assign osc_run = osc_run_r;
	assign upd = update_on_ack_r ? BUS_ACK : BUS_STOP;
	assign clr = wr && a == ledmg_pkg::OFF_MODE_STAT
		&& d[ledmg_pkg::B_FAULT_CLR];
	assign chan_wrap = (chan_cnt_r == CW'(ledmg_pkg::CHAN_CYC - 1));

	// First mode register
	always_ff @(posedge CLK) begin
		if (RST) begin
			autoinc_range_r <= 2'h0;
			sleep_r <= 1'b0;
			subaddr_respond_r <= ledmg_pkg::RST_SUB;
			broadcast_respond_r <= ledmg_pkg::RST_BCAST;
		end else if (wr && a == ledmg_pkg::OFF_MODE_CFG) begin
			autoinc_range_r <= d[ledmg_pkg::B_AUTOINC_HI:
				ledmg_pkg::B_AUTOINC_LO];
			sleep_r <= d[ledmg_pkg::B_SLEEP];
			subaddr_respond_r <= d[ledmg_pkg::B_SUBADDR1_RESPOND:
				ledmg_pkg::B_SUBADDR3_RESPOND];
			broadcast_respond_r <= d[ledmg_pkg::B_BCAST];
		end
	end

	// Second mode register
	always_ff @(posedge CLK) begin
		if (RST) begin
			group_blink_select_r <= 1'b0;
			update_on_ack_r <= 1'b0;
			exp_curve_select_r <= 1'b0;
			thermal_flag_r <= 1'b0;
		end else begin
			thermal_flag_r <= THERMAL;
			if (wr && a == ledmg_pkg::OFF_MODE_STAT) begin
				group_blink_select_r <= d[ledmg_pkg::B_BLINK_SEL];
				update_on_ack_r <= d[ledmg_pkg::B_UPD_ACK];
				exp_curve_select_r <= d[ledmg_pkg::B_EXP_CURVE];
			end
		end
	end

	// Fault flags: a new fault wins over a clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			fault_flags_r <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				fault_flags_r[2*i] <= (fault_flags_r[2*i] && !clr)
					|| FAULT_OPEN[i];
				fault_flags_r[2*i+1] <= (fault_flags_r[2*i+1] && !clr)
					|| FAULT_SHORT[i];
			end
		end
	end

	// Output settings: shadow written by bus, active loaded at update
	always_ff @(posedge CLK) begin
		if (RST) begin
			sel_sh_r <= {CHANNELS{ledmg_pkg::RST_STATE}};
			gduty_sh_r <= ledmg_pkg::RST_GRP_DUTY;
			gperiod_sh_r <= ledmg_pkg::RST_GRP_PERIOD;
			for (int i = 0; i < CHANNELS; i++) begin
				duty_sh_r[i] <= ledmg_pkg::RST_CHAN_DUTY;
			end
		end else if (wr) begin
			for (int r = 0; r < CHANNELS / 4; r++) begin
				if (a == 7'(ledmg_pkg::OFF_STATE_SEL0 + r)) begin
					sel_sh_r[8*r +: 8] <= d;
				end
			end
			if (a == ledmg_pkg::OFF_GRP_DUTY) begin
				gduty_sh_r <= d;
			end
			if (a == ledmg_pkg::OFF_GRP_PERIOD) begin
				gperiod_sh_r <= d;
			end
			for (int i = 0; i < CHANNELS; i++) begin
				if (a == 7'(ledmg_pkg::OFF_CHAN_DUTY0 + i)
					|| a == ledmg_pkg::OFF_BCAST_DUTY) begin
					duty_sh_r[i] <= d;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sel_r <= {CHANNELS{ledmg_pkg::RST_STATE}};
			gduty_r <= ledmg_pkg::RST_GRP_DUTY;
			gperiod_r <= ledmg_pkg::RST_GRP_PERIOD;
			for (int i = 0; i < CHANNELS; i++) begin
				duty_r[i] <= ledmg_pkg::RST_CHAN_DUTY;
			end
		end else if (upd) begin
			sel_r <= sel_sh_r;
			gduty_r <= gduty_sh_r;
			gperiod_r <= gperiod_sh_r;
			duty_r <= duty_sh_r;
		end
	end

	// Read data, one cycle after the read strobe
	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_r <= 8'h00;
		end else if (BUS_REQ.re) begin
			rdata_r <= 8'h00;
			if (a == ledmg_pkg::OFF_MODE_CFG) begin
				rdata_r <= {1'b1, autoinc_range_r, sleep_r,
					subaddr_respond_r, broadcast_respond_r};
			end else if (a == ledmg_pkg::OFF_MODE_STAT) begin
				rdata_r <= {thermal_flag_r, |fault_flags_r,
					group_blink_select_r, 1'b0, update_on_ack_r,
					exp_curve_select_r, 2'h1};
			end else if (a >= ledmg_pkg::OFF_STATE_SEL0
				&& a <= ledmg_pkg::OFF_STATE_SEL3) begin
				rdata_r <= sel_sh_r[8*(a-ledmg_pkg::OFF_STATE_SEL0) +: 8];
			end else if (a == ledmg_pkg::OFF_GRP_DUTY) begin
				rdata_r <= gduty_sh_r;
			end else if (a == ledmg_pkg::OFF_GRP_PERIOD) begin
				rdata_r <= gperiod_sh_r;
			end else if (a >= ledmg_pkg::OFF_CHAN_DUTY0
				&& a <= ledmg_pkg::OFF_CHAN_DUTY15) begin
				rdata_r <= duty_sh_r[4'(a - ledmg_pkg::OFF_CHAN_DUTY0)];
			end else if (a >= ledmg_pkg::OFF_FAULT0
				&& a <= ledmg_pkg::OFF_FAULT3) begin
				rdata_r <= fault_flags_r[8*(a-ledmg_pkg::OFF_FAULT0) +: 8];
			end
		end
	end

	// Oscillator: off in sleep, wake-up delay after sleep clears
	always_ff @(posedge CLK) begin
		if (RST) begin
			osc_r <= ledmg_pkg::OSC_RUN;
			osc_run_r <= 1'b1;
			wake_cnt_r <= '0;
		end else if (sleep_r) begin
			osc_r <= ledmg_pkg::OSC_OFF;
			osc_run_r <= 1'b0;
			wake_cnt_r <= WW'(WAKE_CYC - 1);
		end else begin
			unique case (osc_r)
				ledmg_pkg::OSC_OFF: osc_r <= ledmg_pkg::OSC_WAKE;
				ledmg_pkg::OSC_WAKE: begin
					if (wake_cnt_r == '0) begin
						osc_r <= ledmg_pkg::OSC_RUN;
						osc_run_r <= 1'b1;
					end else begin
						wake_cnt_r <= wake_cnt_r - 1'b1;
					end
				end
				ledmg_pkg::OSC_RUN: osc_r <= ledmg_pkg::OSC_RUN;
				default: begin
					osc_r <= ledmg_pkg::OSC_OFF;
					osc_run_r <= 1'b0;
				end
			endcase
		end
	end

	// Channel period counter, frozen while oscillator is off
	always_ff @(posedge CLK) begin
		if (RST) begin
			chan_cnt_r <= '0;
		end else if (osc_run) begin
			chan_cnt_r <= chan_wrap ? '0 : chan_cnt_r + 1'b1;
		end
	end

	// Blink step: (period code + 1) prescaler steps per phase step
	always_ff @(posedge CLK) begin
		if (RST) begin
			pre_r <= '0;
			bsub_r <= 8'h00;
		end else if (osc_run && group_blink_select_r) begin
			if (pre_r == PW'(BLINK_STEP_CYC - 1)) begin
				pre_r <= '0;
				bsub_r <= (bsub_r >= gperiod_r) ? 8'h00 : bsub_r + 1'b1;
			end else begin
				pre_r <= pre_r + 1'b1;
			end
		end
	end

	assign gstep = group_blink_select_r
		? (pre_r == PW'(BLINK_STEP_CYC - 1) && bsub_r >= gperiod_r)
		: chan_wrap;

	// Group phase, one of 256 steps per group period
	always_ff @(posedge CLK) begin
		if (RST) begin
			gphase_r <= 8'h00;
		end else if (osc_run && gstep) begin
			gphase_r <= gphase_r + 1'b1;
		end
	end

	assign grp_on = gphase_r < gduty_r;

	// Per-channel output stage
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		logic [12:0] prod;
		logic [CW-1:0] thr;
		logic pwm_on;
		logic [1:0] st;
		assign prod = 13'(duty_r[i]) * 13'd25;
		assign thr = CW'(prod[12:3]);
		assign pwm_on = (duty_r[i] == ledmg_pkg::DUTY_FULL)
			|| (chan_cnt_r < thr);
		assign st = sel_r[2*i +: 2];
		always_ff @(posedge CLK) begin
			if (RST) begin
				led_r[i] <= 1'b0;
			end else begin
				unique case (st)
					ledmg_pkg::ST_OFF: led_r[i] <= 1'b0;
					ledmg_pkg::ST_ON: led_r[i] <= !OE_N;
					ledmg_pkg::ST_PWM:
						led_r[i] <= osc_run && pwm_on && !OE_N;
					ledmg_pkg::ST_GRP:
						led_r[i] <= osc_run && pwm_on && grp_on
							&& !OE_N;
				endcase
			end
		end
	end

	assign BUS_RDATA = rdata_r;
	assign SUBADDR_EN = subaddr_respond_r;
	assign BCAST_EN = broadcast_respond_r;
	assign AUTOINC_RANGE = autoinc_range_r;
	assign OSC_RUN = osc_run;
	assign EXP_CURVE = exp_curve_select_r;
	assign LED = led_r;

	property p_autoinc_reads;
		@(posedge CLK) disable iff (RST)
		BUS_REQ.re && a == ledmg_pkg::OFF_MODE_CFG |=> BUS_RDATA[7];
	endproperty
	a_autoinc_reads: assert property (p_autoinc_reads)
		else $error("auto-increment flag read as zero");
	property p_sleep_stops;
		@(posedge CLK) disable iff (RST)
		sleep_r |=> !OSC_RUN;
	endproperty
	a_sleep_stops: assert property (p_sleep_stops)
		else $error("oscillator runs in sleep");
	property p_wake;
		@(posedge CLK) disable iff (RST)
		osc_r == ledmg_pkg::OSC_WAKE && wake_cnt_r == '0 && !sleep_r
		|=> OSC_RUN;
	endproperty
	a_wake: assert property (p_wake)
		else $error("oscillator did not start after wake delay");
	property p_stopped_dark;
		@(posedge CLK) disable iff (RST)
		!osc_run && sel_r[7] |=> !LED[3];
	endproperty
	a_stopped_dark: assert property (p_stopped_dark)
		else $error("modulated output lit with oscillator off");
	property p_bcast;
		@(posedge CLK) disable iff (RST)
		wr && a == ledmg_pkg::OFF_MODE_CFG |=> BCAST_EN == $past(d[0]);
	endproperty
	a_bcast: assert property (p_bcast)
		else $error("broadcast enable not updated");
	property p_fault_set;
		@(posedge CLK) disable iff (RST)
		FAULT_OPEN[0] ##1 BUS_REQ.re && a == ledmg_pkg::OFF_MODE_STAT
		|=> BUS_RDATA[ledmg_pkg::B_ERROR];
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("error summary not set by fault");
	property p_clear;
		@(posedge CLK) disable iff (RST)
		clr && !(|FAULT_OPEN) && !(|FAULT_SHORT) |=> fault_flags_r == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("fault flags survive clear");
	property p_hold;
		@(posedge CLK) disable iff (RST)
		!upd |=> $stable(sel_r) && $stable(gduty_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("settings changed outside update event");
	property p_off;
		@(posedge CLK) disable iff (RST)
		sel_r[1:0] == ledmg_pkg::ST_OFF |=> !LED[0];
	endproperty
	a_off: assert property (p_off)
		else $error("off output lit");
	property p_full;
		@(posedge CLK) disable iff (RST)
		sel_r[3:2] == ledmg_pkg::ST_ON |=> LED[1] == !$past(OE_N);
	endproperty
	a_full: assert property (p_full)
		else $error("fully-on output wrong");
	property p_group_gate;
		@(posedge CLK) disable iff (RST)
		sel_r[7:6] == ledmg_pkg::ST_GRP && !grp_on |=> !LED[3];
	endproperty
	a_group_gate: assert property (p_group_gate)
		else $error("group overlay did not gate output");
	property p_chan_wrap;
		@(posedge CLK) disable iff (RST)
		osc_run && chan_wrap |=> chan_cnt_r == '0;
	endproperty
	a_chan_wrap: assert property (p_chan_wrap)
		else $error("channel period wrong");
endmodule : ledmg_top

// ===== ledmg_host.sv
`timescale 1ns/1ps
module ledmg_host (
	// Clock
	input wire logic clk,
	// Register access toward the block
	output ledmg_pkg::ledmg_bus_t req,
	output logic ack,
	output logic stop,
	input wire logic [7:0] rdata
);
	initial begin
		req = '0;
		ack = 1'b0;
		stop = 1'b0;
	end

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		req.we = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.we = 1'b0;
	endtask : wr

	// Read data is taken once the strobe edge has passed
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge clk);
		req.re = 1'b1;
		req.addr = a;
		@(negedge clk);
		req.re = 1'b0;
		d = rdata;
	endtask : rd

	// One STOP or byte-acknowledge pulse
	task automatic pulse(input logic on_ack);
		@(negedge clk);
		if (on_ack) begin
			ack = 1'b1;
		end else begin
			stop = 1'b1;
		end
		@(negedge clk);
		ack = 1'b0;
		stop = 1'b0;
	endtask : pulse

	// Quiet spell with no access, used while the oscillator wakes
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
endmodule : ledmg_host

// ===== ledmg_top_tb.sv
`timescale 1ns/1ps
module ledmg_top_tb;
	localparam int WAKE = 8;
	localparam int STEP = 4;
	logic clk;
	logic rst;
	ledmg_pkg::ledmg_bus_t bus_req;
	logic bus_ack, bus_stop, oe_n, thermal, bcast_en, osc_run, exp_curve;
	logic [7:0] rdata, rv;
	logic [2:0] subaddr_en;
	logic [1:0] ai_range;
	logic [15:0] f_open, f_short, led;
	logic [7:0] ctl;
	int bad_count, num_checks, cycles, c;

	assign ctl = {ai_range, osc_run, exp_curve, subaddr_en, bcast_en};

	ledmg_top #(.CHANNELS(16), .WAKE_CYC(WAKE), .BLINK_STEP_CYC(STEP))
	u_ledmg_top (
		.CLK(clk), .RST(rst), .BUS_REQ(bus_req), .BUS_ACK(bus_ack),
		.BUS_STOP(bus_stop), .BUS_RDATA(rdata), .SUBADDR_EN(subaddr_en),
		.BCAST_EN(bcast_en), .AUTOINC_RANGE(ai_range), .OSC_RUN(osc_run),
		.EXP_CURVE(exp_curve), .FAULT_OPEN(f_open), .FAULT_SHORT(f_short),
		.THERMAL(thermal), .OE_N(oe_n), .LED(led)
	);

	ledmg_host u_ledmg_host (
		.clk(clk), .req(bus_req), .ack(bus_ack), .stop(bus_stop),
		.rdata(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		u_ledmg_host.rd(a, rv);
		chk({8'h00, rv}, {8'h00, exp});
	endtask : rchk

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_ledmg_host.wr(a, d);
	endtask : wr

	// Cycles an output is lit over a span of n cycles
	task automatic lit(input int idx, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(negedge clk);
			if (led[idx] === 1'b1) begin
				k++;
			end
		end
	endtask : lit

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("[ERR] %0t: run did not complete", $time);
			finish_test();
		end
	end

	initial begin
		rst = 1'b1;
		oe_n = 1'b0;
		thermal = 1'b0;
		f_open = 16'h0000;
		f_short = 16'h0000;
		bad_count = 0;
		num_checks = 0;
		cycles = 0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		rchk(7'h00, 8'h89);
		rchk(7'h01, 8'h01);
		for (int i = 2; i < 6; i++) rchk(7'(i), 8'hAA);
		rchk(7'h06, 8'hFF);
		chk({8'h00, ctl}, 16'h0029);
		// Mode fields, reserved and read-only places
		wr(7'h00, 8'h66);
		rchk(7'h00, 8'hE6);
		chk({8'h00, ctl}, 16'h00E6);
		rchk(7'h4A, 8'h00);
		wr(7'h00, 8'h09);
		wr(7'h01, 8'h2C);
		rchk(7'h01, 8'h2D);
		chk({8'h00, ctl}, 16'h0039);
		wr(7'h01, 8'h00);
		// Fault summary and clear
		@(negedge clk);
		f_short[1] = 1'b1;
		thermal = 1'b1;
		@(negedge clk);
		f_short = 16'h0000;
		rchk(7'h01, 8'hC1);
		thermal = 1'b0;
		wr(7'h46, 8'h00);
		rchk(7'h46, 8'h08);
		wr(7'h01, 8'h10);
		rchk(7'h01, 8'h01);
		rchk(7'h46, 8'h00);
		// Every open and short input at once
		f_open = 16'hFFFF;
		f_short = 16'hFFFF;
		rchk(7'h01, 8'h41);
		f_open = 16'h0000;
		f_short = 16'h0000;
		for (int i = 70; i < 74; i++) rchk(7'(i), 8'hFF);
		wr(7'h01, 8'h10);
		for (int i = 70; i < 74; i++) rchk(7'(i), 8'h00);
		rchk(7'h01, 8'h01);
		// Output states off, on, own duty, group
		wr(7'h02, 8'hE4);
		for (int i = 8; i < 12; i++) wr(7'(i), 8'hFF);
		wr(7'h06, 8'h00);
		chk(led, 16'h0000);
		u_ledmg_host.pulse(1'b0);
		u_ledmg_host.idle(2);
		chk(led, 16'h0006);
		oe_n = 1'b1;
		u_ledmg_host.idle(2);
		chk(led, 16'h0000);
		oe_n = 1'b0;
		// Channel duty, direct and broadcast
		wr(7'h0A, 8'h80);
		u_ledmg_host.pulse(1'b0);
		u_ledmg_host.idle(800);
		lit(2, 800, c);
		chk(16'(c), 16'h0190);
		wr(7'h44, 8'h40);
		u_ledmg_host.pulse(1'b0);
		u_ledmg_host.idle(800);
		lit(2, 800, c);
		chk(16'(c), 16'h00C8);
		// Blinking overlay, applied on acknowledge
		wr(7'h01, 8'h28);
		wr(7'h0B, 8'hFF);
		wr(7'h06, 8'h80);
		u_ledmg_host.pulse(1'b1);
		u_ledmg_host.idle(1024);
		lit(3, 1024, c);
		chk(16'(c), 16'h0200);
		wr(7'h07, 8'h01);
		u_ledmg_host.pulse(1'b1);
		u_ledmg_host.idle(2048);
		lit(3, 2048, c);
		chk(16'(c), 16'h0400);
		// Sleep and wake
		wr(7'h00, 8'h19);
		u_ledmg_host.idle(2);
		chk({15'h0000, osc_run}, 16'h0000);
		lit(3, 1024, c);
		chk(16'(c), 16'h0000);
		chk({15'h0000, led[1]}, 16'h0001);
		wr(7'h00, 8'h09);
		u_ledmg_host.idle(3);
		chk({15'h0000, osc_run}, 16'h0000);
		u_ledmg_host.idle(8);
		chk({15'h0000, osc_run}, 16'h0001);
		// Group state was in use across sleep, so restart
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		rchk(7'h02, 8'hAA);
		finish_test();
	end
endmodule : ledmg_top_tb
